// ===== design/pxi_pkg.sv
package pxi_pkg;

    // Clock rate and the highest serial bit rate the port is built for.
    localparam int CLK_MHZ      = 125;
    localparam int BUS_MAX_KBPS = 400;

    // Target addresses.
    localparam logic [6:0] ADDR_DEFAULT = 7'h44;
    localparam logic [6:0] ADDR_ALT_A   = 7'h46;
    localparam logic [6:0] ADDR_ALT_B   = 7'h47;
    localparam logic [6:0] ADDR_TEST    = 7'h45;

    // Register offsets.
    localparam logic [7:0] REG_EVENT = 8'h00;
    localparam logic [7:0] REG_CMD   = 8'h04;
    localparam logic [7:0] REG_FREQ  = 8'h07;
    localparam logic [7:0] REG_TMO   = 8'h09;

    // Reset values.
    localparam logic [7:0] FREQ_RESET = 8'h00;
    localparam logic [7:0] TMO_RESET  = 8'h00;
    localparam logic [7:0] PTR_RESET  = 8'h00;
    localparam logic [3:0] TMO_OTP    = 4'h4;

    // Command bit positions.
    localparam int CMD_PIN_MODE = 0;
    localparam int CMD_AUTO     = 1;
    localparam int CMD_HALT     = 5;
    localparam int CMD_SENSE    = 6;
    localparam int CMD_RECAL    = 7;

    // Field positions.
    localparam int FREQ_RATE_LSB = 0;
    localparam int FREQ_CT_LSB   = 6;
    localparam int TMO_LSB       = 4;

    // Event register bit positions.
    localparam int EV_PROX  = 0;
    localparam int EV_RECAL = 1;
    localparam int EV_SENSE = 2;
    localparam int EV_AUTO  = 3;

    // Sampling rate codes and periods in milliseconds.
    localparam logic [1:0] RATE_30  = 2'h0;
    localparam logic [1:0] RATE_100 = 2'h1;
    localparam logic [1:0] RATE_8   = 2'h2;
    localparam logic [8:0] PER_30   = 9'h021;
    localparam logic [8:0] PER_100  = 9'h00A;
    localparam logic [8:0] PER_8    = 9'h07D;
    localparam logic [8:0] PER_4    = 9'h0FA;
    localparam logic [8:0] CT_STEP  = 9'h004;
    localparam logic [1:0] OTP_MODE_STANDALONE = 2'h0;

    // Times and derived cycle counts.
    localparam int T_TEST_MODE_US = 1000;
    localparam int T_TICK_US      = 1;
    localparam int T_RECAL_US     = 100;
    localparam int TEST_CYCLES    = T_TEST_MODE_US * CLK_MHZ;
    localparam int TICK_CYCLES    = T_TICK_US * CLK_MHZ * 1000;
    localparam int RECAL_CYCLES   = T_RECAL_US * CLK_MHZ;
    localparam logic [3:0] START_BITS = 4'h3;

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_ADDR,
        LK_WPTR,
        LK_WDATA,
        LK_READ
    } pxi_link_t;

endpackage : pxi_pkg

// ===== design/pxi_sync2.sv
module pxi_sync2 #(
    parameter int W = 1
) (
    // Destination clock.
    input  wire logic         clk,
    // Level in, level out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule : pxi_sync2

// ===== design/pxi_target_port.sv
module pxi_target_port
    import pxi_pkg::*;
#(
    parameter int TEST_CYCLES_P  = TEST_CYCLES,
    parameter int TICK_CYCLES_P  = TICK_CYCLES,
    parameter int RECAL_CYCLES_P = RECAL_CYCLES
) (
    // System clock and reset.
    input  wire logic       CLK,
    input  wire logic       RESET,
    // Serial bus; SCL clocks the link logic.
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    // Strap options.
    input  wire logic [1:0] OTP_ADDR_SEL,
    input  wire logic [1:0] OTP_IC_MODE,
    // Sensing engine.
    input  wire logic       PROX_DET,
    input  wire logic       MOVE_DET,
    output logic            PROX_OUT,
    output logic            SENSE_START,
    output logic            RECAL_BUSY,
    output logic            AUTO_RECAL,
    output logic            SENSE_EN,
    output logic            PIN_MODE,
    output logic [1:0]      CT_FREQ,
    output logic            MOVE_TIMEOUT
);

    // Crossings.
    logic [5:0]  pin_s;
    logic [1:0]  l2c_s;
    logic [7:0]  c2l_s;
    logic        rst_l;

    // System domain state.
    logic        sda_p_q;
    logic        start_tgl_q;
    logic        cmd_p_q;
    logic        poll_p_q;
    logic [31:0] test_cnt_q;
    logic        test_win_q;
    logic        pin_mode_q;
    logic        auto_q;
    logic        sense_en_q;
    logic [31:0] recal_cnt_q;
    logic [31:0] tick_cnt_q;
    logic [8:0]  per_cnt_q;
    logic [7:0]  mv_cnt_q;
    logic [3:0]  ev_q;

    // Link domain state.
    pxi_link_t   state_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic [7:0]  ptr_q;
    logic [7:0]  tx_q;
    logic        ack_q;
    logic        st_p_q;
    logic [7:0]  cmd_q;
    logic        cmd_tgl_q;
    logic        poll_tgl_q;
    logic [7:0]  freq_q;
    logic [7:0]  tmo_q;

    // Combinational helpers, plus the registered copies freq_s and tmo_s.
    logic        scl_s;
    logic        sda_s;
    logic        cmd_ev;
    logic        poll_ev;
    logic        tick;
    logic [7:0]  freq_s;
    logic [7:0]  tmo_s;
    logic [3:0]  tmo_nib;
    logic [8:0]  period;
    logic [7:0]  rx;
    logic [7:0]  ev_b;
    logic [7:0]  rd_b;
    logic [6:0]  own_addr;
    logic        addr_hit;
    logic        start_ev;

    pxi_sync2 #(.W(6)) u_pin_sync (
        .clk (CLK),
        .d   ({SCL, SDA_IN, OTP_ADDR_SEL, OTP_IC_MODE}),
        .q   (pin_s)
    );

    pxi_sync2 #(.W(2)) u_l2c_sync (
        .clk (CLK),
        .d   ({cmd_tgl_q, poll_tgl_q}),
        .q   (l2c_s)
    );

    pxi_sync2 #(.W(8)) u_c2l_sync (
        .clk (SCL),
        .d   ({start_tgl_q, test_win_q, ev_q, pin_s[3:2]}),
        .q   (c2l_s)
    );

    pxi_sync2 #(.W(1)) u_rst_sync (
        .clk (SCL),
        .d   (RESET),
        .q   (rst_l)
    );

    // ---------------- System clock domain ----------------

    assign scl_s   = pin_s[5];
    assign sda_s   = pin_s[4];
    assign cmd_ev  = l2c_s[1] ^ cmd_p_q;
    assign poll_ev = l2c_s[0] ^ poll_p_q;
    assign tick    = (tick_cnt_q == 32'(TICK_CYCLES_P - 1));

    // Start detection needs only a few clocks of the long SCL high time.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sda_p_q     <= 1'b1;
            start_tgl_q <= 1'b0;
        end else begin
            sda_p_q <= sda_s;
            if (scl_s && sda_p_q && !sda_s) begin
                start_tgl_q <= ~start_tgl_q;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            cmd_p_q  <= 1'b0;
            poll_p_q <= 1'b0;
        end else begin
            cmd_p_q  <= l2c_s[1];
            poll_p_q <= l2c_s[0];
        end
    end

    // Register copies are taken once the write toggle has crossed, so no torn word is seen.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            freq_s <= FREQ_RESET;
            tmo_s  <= TMO_RESET;
        end else if (cmd_ev) begin
            freq_s <= freq_q;
            tmo_s  <= tmo_q;
        end
    end

    // The test address is open only for a while after reset.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            test_cnt_q <= 32'(TEST_CYCLES_P);
            test_win_q <= 1'b1;
        end else begin
            if (test_cnt_q != 32'h0) begin
                test_cnt_q <= test_cnt_q - 32'h1;
            end
            test_win_q <= (test_cnt_q != 32'h0);
        end
    end

    // Commands; the byte is stable while its toggle crosses.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_mode_q <= 1'b0;
            auto_q     <= 1'b1;
            sense_en_q <= 1'b1;
        end else if (cmd_ev) begin
            if (cmd_q[CMD_PIN_MODE]) begin
                pin_mode_q <= 1'b1;
            end
            if (cmd_q[CMD_AUTO]) begin
                auto_q <= ~auto_q;
            end
            if (cmd_q[CMD_HALT]) begin
                sense_en_q <= 1'b0;
            end else if (cmd_q[CMD_SENSE]) begin
                sense_en_q <= 1'b1;
            end
        end
    end

    // Calibration runs at reset, on command and after a soft reset.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            recal_cnt_q <= 32'(RECAL_CYCLES_P);
        end else if (cmd_ev && (cmd_q[CMD_RECAL] || cmd_q[CMD_PIN_MODE])) begin
            recal_cnt_q <= 32'(RECAL_CYCLES_P);
        end else if (recal_cnt_q != 32'h0) begin
            recal_cnt_q <= recal_cnt_q - 32'h1;
        end
    end

    // Sampling period in milliseconds for pin output mode.
    always_comb begin
        case (freq_s[FREQ_RATE_LSB +: 2])
            RATE_30: begin
                period = PER_30 + 9'(CT_STEP * {7'h00, freq_s[FREQ_CT_LSB +: 2]});
            end
            RATE_100: begin
                period = PER_100;
            end
            RATE_8: begin
                period = PER_8;
            end
            default: begin
                period = PER_4;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET || (cmd_ev && cmd_q[CMD_PIN_MODE])) begin
            tick_cnt_q <= 32'h0;
            per_cnt_q  <= 9'h000;
        end else begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            if (tick) begin
                per_cnt_q <= (per_cnt_q >= period - 9'h001) ? 9'h000 : per_cnt_q + 9'h001;
            end
        end
    end

    // Serial mode senses once per poll; pin mode runs on its own timer.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SENSE_START <= 1'b0;
        end else if (pin_mode_q) begin
            SENSE_START <= sense_en_q && tick && (per_cnt_q == 9'h000);
        end else begin
            SENSE_START <= sense_en_q && poll_ev;
        end
    end

    // Movement time-out counts sensing cycles, so its accuracy follows polling.
    assign tmo_nib = (pin_s[1:0] != OTP_MODE_STANDALONE) ? tmo_s[TMO_LSB +: 4] : TMO_OTP;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            mv_cnt_q     <= 8'h00;
            MOVE_TIMEOUT <= 1'b0;
        end else begin
            MOVE_TIMEOUT <= 1'b0;
            if (MOVE_DET) begin
                mv_cnt_q <= {tmo_nib, 4'h0};
            end else if (SENSE_START && mv_cnt_q != 8'h00) begin
                mv_cnt_q <= mv_cnt_q - 8'h01;
                MOVE_TIMEOUT <= (mv_cnt_q == 8'h01);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            PROX_OUT   <= 1'b1;
            RECAL_BUSY <= 1'b1;
            AUTO_RECAL <= 1'b1;
            SENSE_EN   <= 1'b1;
            PIN_MODE   <= 1'b0;
            CT_FREQ    <= 2'h0;
            ev_q       <= 4'h0;
        end else begin
            PROX_OUT   <= PROX_DET || (recal_cnt_q != 32'h0);
            RECAL_BUSY <= (recal_cnt_q != 32'h0);
            AUTO_RECAL <= auto_q;
            SENSE_EN   <= sense_en_q;
            PIN_MODE   <= pin_mode_q;
            CT_FREQ    <= freq_s[FREQ_CT_LSB +: 2];
            ev_q[EV_PROX]  <= PROX_OUT;
            ev_q[EV_RECAL] <= RECAL_BUSY;
            ev_q[EV_SENSE] <= sense_en_q;
            ev_q[EV_AUTO]  <= auto_q;
        end
    end

    a_recal_prox_out: assert property (@(posedge CLK) disable iff (RESET)
        (recal_cnt_q != 32'h0) |=> PROX_OUT)
        else $error("proximity output not active during recalibration");

    a_halt_cmd: assert property (@(posedge CLK) disable iff (RESET)
        cmd_ev && cmd_q[CMD_HALT] |=> ##1 !SENSE_EN)
        else $error("halt command left sensing enabled");

    a_enable_cmd: assert property (@(posedge CLK) disable iff (RESET)
        cmd_ev && cmd_q[CMD_SENSE] && !cmd_q[CMD_HALT] |=> ##1 SENSE_EN)
        else $error("enable command did not enable sensing");

    a_auto_toggle: assert property (@(posedge CLK) disable iff (RESET)
        cmd_ev && cmd_q[CMD_AUTO] |=> (auto_q != $past(auto_q)))
        else $error("auto recalibration enable did not invert");

    a_recal_start: assert property (@(posedge CLK) disable iff (RESET)
        cmd_ev && cmd_q[CMD_RECAL] |=> ##1 (RECAL_BUSY && PROX_OUT))
        else $error("recalibration command did not start calibration");

    a_pin_mode: assert property (@(posedge CLK) disable iff (RESET)
        cmd_ev && cmd_q[CMD_PIN_MODE] |=> ##1 (PIN_MODE && $stable(freq_s)))
        else $error("soft reset into pin mode failed");

    a_poll_sense: assert property (@(posedge CLK) disable iff (RESET)
        poll_ev && sense_en_q && !pin_mode_q |=> SENSE_START)
        else $error("poll did not start a sensing cycle");

    // ---------------- Link domain, clocked by SCL ----------------

    assign rx       = {sh_q[6:0], SDA_IN};
    assign start_ev = c2l_s[7] ^ st_p_q;
    assign ev_b     = {4'h0, c2l_s[5:2]};
    assign own_addr = (c2l_s[1:0] == 2'h0) ? ADDR_DEFAULT :
                      (c2l_s[1:0] == 2'h1) ? ADDR_ALT_A : ADDR_ALT_B;
    assign addr_hit = (rx[7:1] == own_addr) || (c2l_s[6] && rx[7:1] == ADDR_TEST);

    always_comb begin
        case (ptr_q)
            REG_EVENT: begin
                rd_b = ev_b;
            end
            REG_FREQ: begin
                rd_b = freq_q;
            end
            REG_TMO: begin
                rd_b = tmo_q;
            end
            default: begin
                rd_b = 8'h00;
            end
        endcase
    end

    always_ff @(posedge SCL) begin
        sh_q   <= rx;
        st_p_q <= rst_l ? 1'b0 : c2l_s[7];
    end

    // Byte engine; the start toggle lands after three bits were shifted.
    always_ff @(posedge SCL) begin
        if (rst_l) begin
            state_q    <= LK_IDLE;
            cnt_q      <= 4'h0;
            ack_q      <= 1'b0;
            ptr_q      <= PTR_RESET;
            tx_q       <= 8'h00;
            poll_tgl_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= LK_ADDR;
            cnt_q   <= START_BITS;
            ack_q   <= 1'b0;
        end else if (state_q != LK_IDLE) begin
            if (cnt_q == 4'h7) begin
                cnt_q <= 4'h8;
                case (state_q)
                    LK_ADDR: begin
                        ack_q <= addr_hit;
                        if (addr_hit) begin
                            state_q    <= rx[0] ? LK_READ : LK_WPTR;
                            tx_q       <= ev_b;
                            poll_tgl_q <= ~poll_tgl_q;
                        end
                    end
                    LK_WPTR: begin
                        ack_q   <= 1'b1;
                        ptr_q   <= rx;
                        state_q <= LK_WDATA;
                    end
                    LK_WDATA: begin
                        ack_q <= 1'b1;
                        ptr_q <= ptr_q + 8'h01;
                    end
                    default: begin
                        ack_q <= 1'b0;
                    end
                endcase
            end else if (cnt_q == 4'h8) begin
                cnt_q <= 4'h0;
                if (state_q == LK_READ && !ack_q) begin
                    if (SDA_IN) begin
                        state_q <= LK_IDLE;
                    end else begin
                        tx_q  <= rd_b;
                        ptr_q <= ptr_q + 8'h01;
                    end
                end else if (!ack_q) begin
                    state_q <= LK_IDLE;
                end
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Register writes land with the last data bit.
    always_ff @(posedge SCL) begin
        if (rst_l) begin
            freq_q    <= FREQ_RESET;
            tmo_q     <= TMO_RESET;
            cmd_q     <= 8'h00;
            cmd_tgl_q <= 1'b0;
        end else if (!start_ev && state_q == LK_WDATA && cnt_q == 4'h7) begin
            case (ptr_q)
                REG_CMD: begin
                    cmd_q     <= rx;
                    cmd_tgl_q <= ~cmd_tgl_q;
                end
                REG_FREQ: begin
                    freq_q    <= rx;
                    cmd_q     <= 8'h00;
                    cmd_tgl_q <= ~cmd_tgl_q;
                end
                REG_TMO: begin
                    tmo_q     <= rx;
                    cmd_q     <= 8'h00;
                    cmd_tgl_q <= ~cmd_tgl_q;
                end
                default: begin
                    freq_q <= freq_q;
                end
            endcase
        end
    end

    // SDA changes only while SCL is low.
    always_ff @(negedge SCL) begin
        SDA_OUT <= 1'b0;
        if (rst_l || state_q == LK_IDLE) begin
            SDA_OE <= 1'b0;
        end else if (cnt_q == 4'h8) begin
            SDA_OE <= ack_q;
        end else if (state_q == LK_READ) begin
            SDA_OE <= ~tx_q[3'h7 - cnt_q[2:0]];
        end else begin
            SDA_OE <= 1'b0;
        end
    end

    a_addr_ack: assert property (@(posedge SCL) disable iff (rst_l)
        !start_ev && state_q == LK_ADDR && cnt_q == 4'h7 && addr_hit
        |=> ack_q && cnt_q == 4'h8 && state_q != LK_ADDR)
        else $error("matching address not acknowledged");

    a_read_event: assert property (@(posedge SCL) disable iff (rst_l)
        !start_ev && state_q == LK_ADDR && cnt_q == 4'h7 && addr_hit && rx[0]
        |=> tx_q == $past(ev_b) && state_q == LK_READ)
        else $error("read did not start with the event byte");

    a_read_hold: assert property (@(posedge SCL) disable iff (rst_l)
        !start_ev && state_q == LK_READ && cnt_q == 4'h8 && ack_q
        |=> tx_q == $past(tx_q))
        else $error("event byte replaced before it was sent");

endmodule : pxi_target_port

// ===== verification/pxi_host.sv
module pxi_host (
    // Bus lines as the host controller sees them.
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // SCL stands high outside frames, apart from these idle pulses around reset.
    task automatic idle_clk(input int n);
        #3;
        repeat (n) begin
            #24 scl = 1'b0;
            #24 scl = 1'b1;
        end
    endtask : idle_clk

    task automatic start();
        #3;
        sda_pull = 1'b1;
        #120 scl = 1'b0;
    endtask : start

    task automatic stop();
        #12 sda_pull = 1'b1;
        #12 scl = 1'b1;
        #120 sda_pull = 1'b0;
        #120;
    endtask : stop

    // SDA moves well inside the low phase so no false START or STOP is seen.
    task automatic bit_cyc(input logic pull, output logic seen);
        #12 sda_pull = pull;
        #12 scl = 1'b1;
        #12 seen = sda;
        #12 scl = 1'b0;
    endtask : bit_cyc

    // Eight bits MSB first, then the acknowledge bit; a read is acked unless last.
    task automatic xfer(input logic [7:0] tx, input logic rd, input logic last,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(~tx[i], s);
            rx[i] = s;
        end
        bit_cyc(rd & ~last, s);
        ack = ~s;
    endtask : xfer
endmodule : pxi_host

// ===== verification/pxi_target_port_tb.sv
module pxi_target_port_tb
    import pxi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RECAL_P = 200;

    logic       clk;
    logic       reset;
    logic       scl;
    logic       sda_pull;
    wire logic  sda;
    logic [1:0] addr_sel;
    logic [1:0] ic_mode;
    logic       prox_det;
    logic       move_det;
    logic       sda_oe;
    logic       sda_out;
    logic       prox_out;
    logic       sense_start;
    logic       recal_busy;
    logic       auto_recal;
    logic       sense_en;
    logic       pin_mode;
    logic [1:0] ct_freq;
    logic       move_timeout;
    logic [7:0] ev;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] cmd_tab [7] = '{8'h02, 8'h1C, 8'h02, 8'h20, 8'h40, 8'h60, 8'h40};
    logic [7:0] exp_tab [7] = '{8'h01, 8'h01, 8'h03, 8'h02, 8'h03, 8'h02, 8'h03};
    int         err_total  = 0;
    int         num_checks = 0;
    int         n_start    = 0;
    int         n_tmo      = 0;
    int         n0;

    // Open-drain wire with its pull-up.
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));

    pxi_target_port #(
        .TEST_CYCLES_P (400),
        .TICK_CYCLES_P (10),
        .RECAL_CYCLES_P(RECAL_P)
    ) i_pxi_target_port (
        .CLK         (clk),
        .RESET       (reset),
        .SCL         (scl),
        .SDA_IN      (sda),
        .SDA_OUT     (sda_out),
        .SDA_OE      (sda_oe),
        .OTP_ADDR_SEL(addr_sel),
        .OTP_IC_MODE (ic_mode),
        .PROX_DET    (prox_det),
        .MOVE_DET    (move_det),
        .PROX_OUT    (prox_out),
        .SENSE_START (sense_start),
        .RECAL_BUSY  (recal_busy),
        .AUTO_RECAL  (auto_recal),
        .SENSE_EN    (sense_en),
        .PIN_MODE    (pin_mode),
        .CT_FREQ     (ct_freq),
        .MOVE_TIMEOUT(move_timeout)
    );

    pxi_host i_pxi_host (
        .scl     (scl),
        .sda_pull(sda_pull),
        .sda     (sda)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counts the one-cycle pulses.
    always @(negedge clk) begin
        n_start += int'(sense_start === 1'b1);
        n_tmo   += int'(move_timeout === 1'b1);
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic wait_recal();
        int k;
        k = 0;
        while (recal_busy !== 1'b0 && k < 400) begin
            cyc(1);
            k++;
        end
        if (k == 400) begin
            err_total++;
            end_sim();
        end
    endtask : wait_recal

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] r;
        logic       a;
        i_pxi_host.xfer(b, 1'b0, 1'b0, r, a);
        check(8'(a), 8'(exp_ack));
    endtask : send

    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] val);
        i_pxi_host.start();
        send({ADDR_DEFAULT, 1'b0}, 1'b1);
        send(ptr, 1'b1);
        send(val, 1'b1);
        i_pxi_host.stop();
        cyc(10);
    endtask : wr_reg

    // Pointer write, then the event byte and two register bytes.
    task automatic rd3(input logic [7:0] ptr);
        logic a;
        wr_ptr: begin
            i_pxi_host.start();
            send({ADDR_DEFAULT, 1'b0}, 1'b1);
            send(ptr, 1'b1);
            i_pxi_host.stop();
        end
        i_pxi_host.start();
        send({ADDR_DEFAULT, 1'b1}, 1'b1);
        i_pxi_host.xfer(8'hFF, 1'b1, 1'b0, ev, a);
        i_pxi_host.xfer(8'hFF, 1'b1, 1'b0, b0, a);
        i_pxi_host.xfer(8'hFF, 1'b1, 1'b1, b1, a);
        i_pxi_host.stop();
        cyc(10);
    endtask : rd3

    task automatic poll(input logic [6:0] addr, input logic exp_ack);
        i_pxi_host.start();
        send({addr, 1'b0}, exp_ack);
        i_pxi_host.stop();
        cyc(10);
    endtask : poll

    initial begin
        reset    = 1'b1;
        addr_sel = 2'h0;
        ic_mode  = 2'h1;
        prox_det = 1'b0;
        move_det = 1'b0;
        fork
            i_pxi_host.idle_clk(3);
        join_none
        cyc(19);
        check({3'h0, pin_mode, auto_recal, sense_en, ct_freq}, 8'h0C);
        cyc(1);
        reset = 1'b0;
        i_pxi_host.idle_clk(4);
        check({recal_busy, prox_out}, 8'h03);
        poll(ADDR_TEST, 1'b1);
        wait_recal();
        check(prox_out, 8'h00);
        done("power_on");
        wr_reg(REG_FREQ, 8'hC1);
        rd3(8'h06);
        check(ev, 8'h0C);
        check(b0, 8'h00);
        check(b1, 8'hC1);
        check(ct_freq, 8'h03);
        done("registers");
        for (int i = 0; i < 7; i++) begin
            wr_reg(REG_CMD, cmd_tab[i]);
            check({pin_mode, recal_busy, auto_recal, sense_en}, exp_tab[i]);
        end
        wr_reg(REG_CMD, 8'h80);
        check({recal_busy, prox_out}, 8'h03);
        wait_recal();
        check(prox_out, 8'h00);
        n0 = n_start;
        poll(ADDR_DEFAULT, 1'b1);
        check(8'(n_start - n0), 8'h01);
        wr_reg(REG_CMD, 8'h20);
        n0 = n_start;
        poll(ADDR_DEFAULT, 1'b1);
        check(8'(n_start - n0), 8'h00);
        wr_reg(REG_CMD, 8'h40);
        poll(ADDR_TEST, 1'b0);
        done("commands");
        wr_reg(REG_TMO, 8'h10);
        move_det = 1'b1;
        cyc(1);
        move_det = 1'b0;
        n0 = n_tmo;
        repeat (15) poll(ADDR_DEFAULT, 1'b1);
        check(8'(n_tmo - n0), 8'h00);
        poll(ADDR_DEFAULT, 1'b1);
        check(8'(n_tmo - n0), 8'h01);
        done("timeout");
        for (int s = 1; s < 4; s++) begin
            addr_sel = 2'(s);
            cyc(5);
            poll((s == 1) ? ADDR_ALT_A : ADDR_ALT_B, 1'b1);
            poll(ADDR_DEFAULT, 1'b0);
        end
        addr_sel = 2'h0;
        cyc(5);
        done("address");
        wr_reg(REG_CMD, 8'h01);
        check({4'h0, pin_mode, recal_busy, ct_freq}, 8'h0F);
        wait_recal();
        n0 = n_start;
        cyc(1000);
        check(8'(n_start - n0), 8'h0A);
        wr_reg(REG_FREQ, 8'h80);
        n0 = n_start;
        cyc(4100);
        check(8'(n_start - n0), 8'h0A);
        done("pin_mode");
        reset = 1'b1;
        i_pxi_host.idle_clk(4);
        cyc(1);
        reset = 1'b0;
        i_pxi_host.idle_clk(4);
        check({4'h0, pin_mode, recal_busy, ct_freq}, 8'h04);
        wr_reg(REG_FREQ, 8'hC1);
        check(ct_freq, 8'h03);
        done("reset");
        end_sim();
    end
endmodule : pxi_target_port_tb
